// ===== design/idrb_regs.svh
// Register numbers, lengths, field positions and filler for the identity bank.
// Assumes inclusion by bare name from the bank module.
`ifndef IDRB_REGS_SVH
`define IDRB_REGS_SVH

// Register file numbers
`define IDRB_FILE_CHIP_ID 6'h00
`define IDRB_FILE_EUI 6'h01

// Register lengths in octets
`define IDRB_LEN_CHIP_ID 7'h04
`define IDRB_LEN_EUI 7'h08

// Filler returned by unused locations
`define IDRB_FILLER 32'hDEAD_DEAD

// Chip identifier field positions
`define IDRB_MINOR_LSB 0
`define IDRB_MINOR_MSB 3
`define IDRB_MAJOR_LSB 4
`define IDRB_MAJOR_MSB 7
`define IDRB_TYPE_LSB 8
`define IDRB_TYPE_MSB 15
`define IDRB_TAG_LSB 16
`define IDRB_TAG_MSB 31

// Unique address split
`define IDRB_EXT_MSB 39
`define IDRB_CO_LSB 40
`define IDRB_CO_MSB 63
`define IDRB_EUI_OCTETS 8

// Reset values and pointer step
`define IDRB_EUI_RST 64'h0000_0000_0000_0000
`define IDRB_PTR_RST 7'h00
`define IDRB_OCTET_RST 8'h00
`define IDRB_PTR_STEP 7'h01

`endif

// ===== design/idrb_pkg.sv
// Types shared by the identity register bank and its bench.
// Assumes idrb_regs.svh holds the numeric constants.
package idrb_pkg;

  typedef logic [7:0] idrb_octet_type;
  typedef logic [5:0] idrb_file_type;
  typedef logic [6:0] idrb_index_type;

  // Direction of a host transaction
  typedef enum logic {
    IDRB_READ = 1'b0,
    IDRB_WRITE = 1'b1
  } idrb_dir_type;

endpackage : idrb_pkg

// ===== design/idrb_bank.sv
// Identity register bank: fixed chip identifier and 64-bit unique address.
// Assumes a host-side serial deframer delivers start and octet strobes on clk.
`timescale 1ns/1ps
`include "idrb_regs.svh"

module idrb_bank #(
  parameter logic [3:0] MINOR_REVISION = 4'h0,  // Arbitrary value
  parameter logic [3:0] MAJOR_VERSION = 4'h0,   // Arbitrary value
  parameter logic [7:0] DEVICE_TYPE = 8'h00,    // Arbitrary value
  parameter logic [15:0] REGISTER_TAG = 16'h0000 // Arbitrary value
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host transaction start
  input wire logic txn_start,
  input wire idrb_pkg::idrb_dir_type txn_dir,
  input wire idrb_pkg::idrb_file_type txn_file,
  input wire idrb_pkg::idrb_index_type txn_index,
  // Host octet transfer
  input wire logic octet_strobe,
  input wire idrb_pkg::idrb_octet_type octet_wdata,
  output logic octet_rvalid,
  output idrb_pkg::idrb_octet_type octet_rdata,
  // One-time memory load at init or wake
  input wire logic otp_load,
  input wire logic [63:0] otp_eui,
  // Receive frame filter compare
  input wire logic filter_enable,
  input wire logic rx_dest_valid,
  input wire logic [63:0] rx_dest_addr,
  output logic rx_accept,
  output logic rx_reject,
  // Current unique address
  output logic [63:0] extended_unique_address
);

  idrb_pkg::idrb_dir_type dir_reg;
  idrb_pkg::idrb_file_type file_reg;
  idrb_pkg::idrb_index_type ptr_reg;
  idrb_pkg::idrb_octet_type rdata_reg;
  logic rvalid_reg;
  logic [63:0] eui_reg;
  logic [31:0] chip_identifier;
  logic [31:0] filler;
  idrb_pkg::idrb_octet_type filler_octet;
  idrb_pkg::idrb_octet_type read_octet;
  logic eui_wr;
  logic accept_reg;
  logic reject_reg;
  logic chip_hit;
  logic eui_hit;
  logic octet_take;
  logic read_take;
  logic [7:0] octet_sel;
  logic addr_match;
  logic accept_next;
  logic reject_next;
  idrb_pkg::idrb_index_type ptr_next;

  // Reset image of the unique address, sliced per octet below
  localparam logic [63:0] EUI_RST = `IDRB_EUI_RST;

  // Location decode of the current pointer
  always_comb begin
    chip_hit = 1'b0;
    eui_hit = 1'b0;
    if (file_reg == `IDRB_FILE_CHIP_ID && ptr_reg < `IDRB_LEN_CHIP_ID) begin
      chip_hit = 1'b1;
    end
    if (file_reg == `IDRB_FILE_EUI && ptr_reg < `IDRB_LEN_EUI) begin
      eui_hit = 1'b1;
    end
  end

  // Octet moves only when no new transaction starts in the same cycle
  assign octet_take = octet_strobe && !txn_start;
  assign read_take = octet_take && dir_reg == idrb_pkg::IDRB_READ;

  // Fixed identifier assembled from constant fields
  always_comb begin
    chip_identifier = '0;
    chip_identifier[`IDRB_MINOR_MSB:`IDRB_MINOR_LSB] = MINOR_REVISION;
    chip_identifier[`IDRB_MAJOR_MSB:`IDRB_MAJOR_LSB] = MAJOR_VERSION;
    chip_identifier[`IDRB_TYPE_MSB:`IDRB_TYPE_LSB] = DEVICE_TYPE;
    chip_identifier[`IDRB_TAG_MSB:`IDRB_TAG_LSB] = REGISTER_TAG;
  end

  assign filler = `IDRB_FILLER;

  // Filler octet follows the octet position within a word
  always_comb begin
    case (ptr_reg[1:0])
      2'h0: filler_octet = filler[7:0];
      2'h1: filler_octet = filler[15:8];
      2'h2: filler_octet = filler[23:16];
      default: filler_octet = filler[31:24];
    endcase
  end

  // Read mux, octet index counts up from the least significant octet
  always_comb begin
    read_octet = filler_octet;
    if (chip_hit) begin
      read_octet = chip_identifier[{ptr_reg[1:0], 3'h0} +: 8];
    end else if (eui_hit) begin
      read_octet = eui_reg[{ptr_reg[2:0], 3'h0} +: 8];
    end
  end

  // Next pointer: start index, else one step per octet
  always_comb begin
    ptr_next = ptr_reg;
    if (txn_start) begin
      ptr_next = txn_index;
    end else if (octet_strobe) begin
      ptr_next = ptr_reg + `IDRB_PTR_STEP;
    end
  end

  // Transaction pointer: loaded at start, steps after each octet
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dir_reg <= idrb_pkg::IDRB_READ;
      file_reg <= `IDRB_FILE_CHIP_ID;
      ptr_reg <= `IDRB_PTR_RST;
    end else begin
      ptr_reg <= ptr_next;
      if (txn_start) begin
        dir_reg <= txn_dir;
        file_reg <= txn_file;
      end
    end
  end

  // Registered read data, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= `IDRB_OCTET_RST;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= read_take;
      if (read_take) begin
        rdata_reg <= read_octet;
      end
    end
  end

  // Only the unique address file accepts writes, within its length
  assign eui_wr = octet_take && dir_reg == idrb_pkg::IDRB_WRITE && eui_hit;

  // Per-octet storage: memory load, then host write of that octet wins
  // A write and a load in one cycle keep the host octet and load the rest
  genvar gi;
  generate
    for (gi = 0; gi < `IDRB_EUI_OCTETS; gi = gi + 1) begin : g_eui
      // Octet select for this storage slot
      assign octet_sel[gi] = eui_wr && ptr_reg[2:0] == 3'(gi);
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          eui_reg[gi*8 +: 8] <= EUI_RST[gi*8 +: 8];
        end else if (octet_sel[gi]) begin
          eui_reg[gi*8 +: 8] <= octet_wdata;
        end else if (otp_load) begin
          eui_reg[gi*8 +: 8] <= otp_eui[gi*8 +: 8];
        end
      end
    end
  endgenerate

  // Full 64-bit compare against the live unique address
  always_comb begin
    addr_match = rx_dest_addr == eui_reg;
    accept_next = 1'b0;
    reject_next = 1'b0;
    if (rx_dest_valid) begin
      accept_next = !filter_enable || addr_match;
      reject_next = filter_enable && !addr_match;
    end
  end

  // Long destination verdict for the frame filter, one cycle later
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      accept_reg <= 1'b0;
      reject_reg <= 1'b0;
    end else begin
      accept_reg <= accept_next;
      reject_reg <= reject_next;
    end
  end

  assign octet_rvalid = rvalid_reg;
  assign octet_rdata = rdata_reg;
  assign rx_accept = accept_reg;
  assign rx_reject = reject_reg;
  assign extended_unique_address = eui_reg;

endmodule : idrb_bank

// ===== bench/idrb_checker.sv
// Port checker for the identity bank.
// Assumes a bind onto idrb_bank with one clock.
`timescale 1ns/1ps
module idrb_checker (
  // Clock, reset and host port
  input wire logic clk,
  input wire logic rst_n,
  input wire logic txn_start,
  input wire logic octet_strobe,
  input wire logic octet_rvalid,
  input wire idrb_pkg::idrb_octet_type octet_rdata,
  // Load and filter
  input wire logic otp_load,
  input wire logic [63:0] otp_eui,
  input wire logic filter_enable,
  input wire logic rx_dest_valid,
  input wire logic [63:0] rx_dest_addr,
  input wire logic rx_accept,
  input wire logic rx_reject,
  input wire logic [63:0] extended_unique_address
);
  wire [63:0] ua = extended_unique_address;
  // Single domain
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_rvalid_cause:
  assert property (octet_rvalid |-> $past(octet_strobe) && !$past(txn_start)) else $error("rvalid");
  a_rdata_hold:
  assert property (!octet_rvalid |-> $stable(octet_rdata)) else $error("rdata moved");
  a_verdict_one:
  assert property (rx_dest_valid |=> rx_accept ^ rx_reject) else $error("verdict");
  a_verdict_cause:
  assert property (!rx_dest_valid |=> !rx_accept && !rx_reject) else $error("stray verdict");
  a_filter_match:
  assert property (rx_dest_valid && filter_enable |=> rx_accept == ($past(rx_dest_addr) == $past(ua)))
    else $error("match");
  a_filter_off:
  assert property (rx_dest_valid && !filter_enable |=> rx_accept) else $error("filter off");
  a_otp_load:
  assert property (otp_load && !octet_strobe |=> ua == $past(otp_eui)) else $error("load");
  a_uaddr_hold:
  assert property (!otp_load && !octet_strobe |=> $stable(ua)) else $error("address moved");
endmodule : idrb_checker

bind idrb_bank idrb_checker u_chk (.clk, .rst_n, .txn_start, .octet_strobe, .octet_rvalid,
  .octet_rdata, .otp_load, .otp_eui, .filter_enable, .rx_dest_valid, .rx_dest_addr,
  .rx_accept, .rx_reject, .extended_unique_address);

// ===== bench/idrb_host.sv
// Host model on the octet transaction port.
// Assumes the bench calls xfer; drives at the falling edge.
`timescale 1ns/1ps
module idrb_host (
  // Clock and answer
  input wire logic clk,
  input wire logic octet_rvalid,
  input wire idrb_pkg::idrb_octet_type octet_rdata,
  // Requests
  output logic txn_start = 1'b0,
  output idrb_pkg::idrb_dir_type txn_dir = idrb_pkg::IDRB_READ,
  output idrb_pkg::idrb_file_type txn_file = 6'h00,
  output idrb_pkg::idrb_index_type txn_index = 7'h00,
  output logic octet_strobe = 1'b0,
  output idrb_pkg::idrb_octet_type octet_wdata = 8'h00
);
  // Start, then n octets back to back, low octet first
  task automatic xfer(input idrb_pkg::idrb_dir_type d, input idrb_pkg::idrb_file_type f,
    input idrb_pkg::idrb_index_type x, input int n, input logic [63:0] w, output logic [63:0] r);
    r = 64'h0;
    @(negedge clk);
    txn_start = 1'b1;
    txn_dir = d;
    {txn_file, txn_index} = {f, x};
    @(negedge clk);
    txn_start = 1'b0;
    for (int i = 0; i < n; i++) begin
      {octet_strobe, octet_wdata} = {1'b1, w[8*i+:8]};
      @(negedge clk);
      r[8*i+:8] = octet_rvalid ? octet_rdata : 8'hxx;
    end
    {octet_strobe, octet_wdata} = {1'b0, ~octet_wdata}; // Released data inverted
  endtask : xfer
endmodule : idrb_host

// ===== bench/test_idrb_bank.sv
// Bench for the identity bank: host calls with expected values.
// Assumes the checker binds itself to the bank.
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, e); end end
module test_idrb_bank;
  localparam logic [63:0] A = 64'h0123_4567_89AB_CDEF;
  localparam logic [63:0] B = 64'h0123_45A5_5AAB_CDEF;
  localparam logic [63:0] CHIP = 64'h5A3C_4279; // Identifier built from the bank parameters
  logic clk = 1'b0, rst_n = 1'b0, otp_load = 1'b0, filter_enable = 1'b0, rx_dest_valid = 1'b0;
  logic [63:0] otp_eui = 64'h0, rx_dest_addr = 64'h0, ua, r;
  logic txn_start, octet_strobe, octet_rvalid, rx_accept, rx_reject;
  idrb_pkg::idrb_dir_type txn_dir;
  idrb_pkg::idrb_file_type txn_file;
  idrb_pkg::idrb_index_type txn_index;
  idrb_pkg::idrb_octet_type octet_wdata, octet_rdata;
  idrb_pkg::idrb_file_type fil [4] = '{6'h00, 6'h02, 6'h3F, 6'h01};
  idrb_pkg::idrb_index_type idx [4] = '{7'h04, 7'h00, 7'h00, 7'h08};
  int error_cnt = 0, num_checks = 0, cycles = 0;
  idrb_bank #(.MINOR_REVISION(4'h9), .MAJOR_VERSION(4'h7), .DEVICE_TYPE(8'h42),
    .REGISTER_TAG(16'h5A3C)) dut (.clk, .rst_n, .txn_start, .txn_dir, .txn_file, .txn_index,
    .octet_strobe, .octet_wdata, .octet_rvalid, .octet_rdata, .otp_load, .otp_eui,
    .filter_enable, .rx_dest_valid, .rx_dest_addr, .rx_accept, .rx_reject,
    .extended_unique_address(ua));
  idrb_host host (.clk, .octet_rvalid, .octet_rdata, .txn_start, .txn_dir, .txn_file,
    .txn_index, .octet_strobe, .octet_wdata);
  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end
  // Cycle ceiling against a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles > 2000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic rd(input idrb_pkg::idrb_file_type f, input idrb_pkg::idrb_index_type x,
    input int n, input logic [63:0] e);
    host.xfer(idrb_pkg::IDRB_READ, f, x, n, 64'h0, r);
    `CHK(r, e)
  endtask : rd
  task automatic ld(input logic [63:0] v);
    @(negedge clk);
    {otp_load, otp_eui} = {1'b1, v};
    @(negedge clk);
    {otp_load, otp_eui} = {1'b0, ~v};
    `CHK(ua, v)
  endtask : ld
  task automatic rx(input logic en, input logic [63:0] a, input logic acc);
    @(negedge clk);
    {filter_enable, rx_dest_valid, rx_dest_addr} = {en, 1'b1, a};
    @(negedge clk);
    {rx_dest_valid, rx_dest_addr} = {1'b0, ~a};
    `CHK({rx_accept, rx_reject}, {acc, !acc})
  endtask : rx
  // Main sequence after a 16-cycle reset
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    `CHK(ua, 64'h0)
    rd(6'h00, 7'h00, 4, CHIP);
    $display("identifier test done");
    ld(A);
    rd(6'h01, 7'h00, 8, A);
    rd(6'h01, 7'h05, 1, 64'h45);
    host.xfer(idrb_pkg::IDRB_WRITE, 6'h01, 7'h03, 2, 64'hA55A, r);
    `CHK(ua, B)
    rd(6'h01, 7'h00, 8, B);
    $display("address tests done");
    rx(1'b1, B, 1'b1);
    rx(1'b1, A, 1'b0);
    rx(1'b0, A, 1'b1);
    $display("filter tests done");
    host.xfer(idrb_pkg::IDRB_WRITE, 6'h00, 7'h00, 4, 64'hFFFF_FFFF, r);
    `CHK(ua, B)
    rd(6'h00, 7'h00, 4, CHIP);
    for (int k = 0; k < 4; k++) rd(fil[k], idx[k], 4, 64'hDEAD_DEAD);
    $display("filler tests done");
    ld(A);
    $display("identity bank sequence done");
    complete_run();
  end
endmodule : test_idrb_bank
